// ===== hdl/rsc_ctrl.sv
/*
 * Reference switch and power-on control with an AXI4-Lite register slave.
 * Assumes pins from outside are asynchronous and synchronised here; the analog
 * supply, regulator, calibration and lock indications arrive as pins.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_ctrl
    import rsc_pkg::*;
#(
    parameter int MODE_W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supplyOk,
    input wire logic regulatorOk,
    input wire logic inputModeStrap,
    input wire logic [MON_STRAP_W-1:0] monitorClockStrap,
    input wire logic clockInputA,
    input wire logic clockInputB,
    input wire logic monitorClockIn,
    input wire logic sourceSelect,
    input wire logic calDone,
    input wire logic pllLocked,
    output logic regulatorEn,
    output logic rxDiffMode,
    output logic monDiffMode,
    output logic [2:0] monFreqSel,
    output logic pllRefSel,
    output logic refOutEn,
    output logic calStart,
    output logic lockDetect,
    output logic outputDivEn,
    output logic activeInputFlag,
    output logic switchoverBusy,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    initial begin
        if (MODE_W != 1) $error("rsc_ctrl: only one mode bit is supported");
    end

    // Two-flop synchronisers for every pin input.
    localparam int NS = 10 + MON_STRAP_W;
    logic [NS-1:0] syncA_r, syncB_r;
    logic [NS-1:0] pinsIn;
    assign pinsIn = {monitorClockStrap, pllLocked, calDone, sourceSelect, monitorClockIn,
        clockInputB, clockInputA, inputModeStrap, regulatorOk, supplyOk, 1'b0};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_r <= '0;
            syncB_r <= '0;
        end else begin
            syncA_r <= pinsIn;
            syncB_r <= syncA_r;
        end
    end
    logic supS, regS, modeS, clkAS, clkBS, monS, selS, calS, lockS;
    logic [MON_STRAP_W-1:0] monStrapS;
    assign {monStrapS, lockS, calS, selS, monS, clkBS, clkAS, modeS, regS, supS} =
        syncB_r[NS-1:1];

    logic lostA, lostB, lostM;
    rsc_loss_det uLostA (.sys_clk(sys_clk), .rst_n(rst_n), .clkSync(clkAS), .lost(lostA));
    rsc_loss_det uLostB (.sys_clk(sys_clk), .rst_n(rst_n), .clkSync(clkBS), .lost(lostB));
    rsc_loss_det uLostM (.sys_clk(sys_clk), .rst_n(rst_n), .clkSync(monS), .lost(lostM));

    // Software reset returns the sequencer to ST_POR and the switch logic to SW_IDLE, but keeps the active input until the strap scan.
    logic softRst_r, softRst_nxt;

    // Power-on sequencer.
    rsc_pwr_t pwr_r, pwr_nxt;
    logic mode_r, mode_nxt;
    logic [MON_STRAP_W-1:0] monCfg_r, monCfg_nxt;
    logic active_r, active_nxt;
    logic busy_r, busy_nxt;
    rsc_sw_t sw_r, sw_nxt;
    logic req_r, req_nxt;
    logic refLost;
    assign refLost = active_r ? lostB : lostA;

    always_comb begin
        pwr_nxt = pwr_r;
        mode_nxt = mode_r;
        monCfg_nxt = monCfg_r;
        unique case (pwr_r)
            ST_POR: pwr_nxt = ST_SUPPLY;
            ST_SUPPLY: if (supS) begin
                pwr_nxt = ST_REGUL;
            end
            ST_REGUL: if (regS) begin
                pwr_nxt = ST_SCAN;
            end
            ST_SCAN: begin
                mode_nxt = modeS;
                monCfg_nxt = monStrapS;
                pwr_nxt = ST_RXCFG;
            end
            ST_RXCFG: pwr_nxt = ST_WAITREF;
            ST_WAITREF: if (!refLost) begin
                pwr_nxt = ST_CAL;
            end
            ST_CAL: if (calS) begin
                pwr_nxt = ST_WAITLOCK;
            end
            ST_WAITLOCK: if (lockS) begin
                pwr_nxt = ST_RUN;
            end
            ST_RUN: if (!lockS) begin
                pwr_nxt = ST_WAITLOCK;
            end
            default: pwr_nxt = ST_POR;
        endcase
        if (softRst_r) begin
            pwr_nxt = ST_POR;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_r <= ST_POR;
            mode_r <= 1'b0;
            monCfg_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            mode_r <= mode_nxt;
            monCfg_r <= monCfg_nxt;
        end
    end

    logic running, seeded_r, seeded_nxt;
    assign running = (pwr_r == ST_RUN);

    // Switchover state machine.
    always_comb begin
        sw_nxt = sw_r;
        active_nxt = active_r;
        busy_nxt = busy_r;
        req_nxt = req_r;
        seeded_nxt = seeded_r;
        if (!seeded_r && pwr_r == ST_SCAN) begin
            active_nxt = selS;
            seeded_nxt = 1'b1;
        end else if (seeded_r) begin
            unique case (sw_r)
                SW_IDLE: if (selS != active_r) begin
                    req_nxt = selS;
                    busy_nxt = 1'b1;
                    sw_nxt = SW_WAIT;
                end
                SW_WAIT: begin
                    if (lostA || lostB) begin
                        sw_nxt = SW_STALL;
                    end else if (running) begin
                        active_nxt = req_r;
                        busy_nxt = 1'b0;
                        sw_nxt = SW_IDLE;
                    end
                end
                SW_STALL: if (!lostA && !lostB) begin
                    sw_nxt = SW_WAIT;
                end
                default: sw_nxt = SW_IDLE;
            endcase
        end
        if (softRst_r) begin
            sw_nxt = SW_IDLE;
            busy_nxt = 1'b0;
            seeded_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_r <= SW_IDLE;
            active_r <= 1'b0;
            busy_r <= 1'b0;
            req_r <= 1'b0;
            seeded_r <= 1'b0;
        end else begin
            sw_r <= sw_nxt;
            active_r <= active_nxt;
            busy_r <= busy_nxt;
            req_r <= req_nxt;
            seeded_r <= seeded_nxt;
        end
    end

    // Outputs driven from registers.
    logic [11:0] outs_r, outs_nxt;
    always_comb begin
        outs_nxt[0] = (pwr_r != ST_POR && pwr_r != ST_SUPPLY);
        outs_nxt[1] = mode_r;
        outs_nxt[2] = (monCfg_r >= 3'(MON_FREQ_COUNT));
        outs_nxt[5:3] = (monCfg_r >= 3'(MON_FREQ_COUNT)) ?
            monCfg_r - 3'(MON_FREQ_COUNT) : monCfg_r;
        outs_nxt[6] = active_r;
        outs_nxt[7] = (pwr_r == ST_CAL || pwr_r == ST_WAITLOCK || running);
        outs_nxt[8] = (pwr_r == ST_CAL);
        outs_nxt[9] = running;
        outs_nxt[10] = running && lockS;
        outs_nxt[11] = busy_r;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outs_r <= '0;
        end else begin
            outs_r <= outs_nxt;
        end
    end
    assign regulatorEn = outs_r[0];
    assign rxDiffMode = outs_r[1];
    assign monDiffMode = outs_r[2];
    assign monFreqSel = outs_r[5:3];
    assign pllRefSel = outs_r[6];
    assign refOutEn = outs_r[7];
    assign calStart = outs_r[8];
    assign lockDetect = outs_r[9];
    assign outputDivEn = outs_r[10];
    assign activeInputFlag = active_r;
    assign switchoverBusy = busy_r;

    // AXI4-Lite slave.
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bv_r, bv_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic [1:0] br_r, br_nxt;
    logic rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0] rr_r, rr_nxt;
    logic [31:0] swCount_r, swCount_nxt;
    logic [31:0] statusWord;
    assign statusWord = rsc_sel_bit(active_r, ST_ACTIVE_BIT) | rsc_sel_bit(busy_r, ST_BUSY_BIT)
        | rsc_sel_bit(lockDetect, ST_LOCK_BIT) | rsc_sel_bit(outputDivEn, ST_OUTEN_BIT)
        | rsc_sel_bit(sw_r == SW_STALL, ST_STALL_BIT) | rsc_sel_bit(lostA, ST_LOSTA_BIT)
        | rsc_sel_bit(lostB, ST_LOSTB_BIT) | rsc_sel_bit(lostM, ST_LOSTM_BIT)
        | (32'(pwr_r) << ST_STATE_LSB);

    assign s_axi_awready = !awHeld_r && !bv_r;
    assign s_axi_wready = !wHeld_r && !bv_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rd_r;
    assign s_axi_rresp = rr_r;

    always_comb begin
        awHeld_nxt = awHeld_r;
        wHeld_nxt = wHeld_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        bv_nxt = bv_r;
        br_nxt = br_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        softRst_nxt = 1'b0;
        swCount_nxt = swCount_r;
        if (busy_r && !busy_nxt && !softRst_r) begin
            swCount_nxt = swCount_r + 32'h0000_0001;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
            wd_nxt = s_axi_wdata;
            ws_nxt = s_axi_wstrb;
        end
        if (awHeld_r && wHeld_r) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = RESP_OKAY;
            if (awa_r == ADDR_CTRL) begin
                softRst_nxt = ws_r[0] && wd_r[CTRL_SOFT_RST_BIT];
            end else if (awa_r != ADDR_STATUS && awa_r != ADDR_STRAP
                    && awa_r != ADDR_SWCOUNT) begin
                br_nxt = RESP_SLVERR;
            end
        end
        if (bv_r && s_axi_bready) begin
            bv_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_nxt = 1'b1;
            rr_nxt = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_CTRL: rd_nxt = CTRL_RESET;
                ADDR_STATUS: rd_nxt = statusWord;
                ADDR_STRAP: rd_nxt = rsc_sel_bit(mode_r, STRAP_MODE_BIT)
                    | (32'(monCfg_r) << STRAP_MON_LSB);
                ADDR_SWCOUNT: rd_nxt = swCount_r;
                default: begin
                    rd_nxt = 32'h0000_0000;
                    rr_nxt = RESP_SLVERR;
                end
            endcase
        end else if (rv_r && s_axi_rready) begin
            rv_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            ws_r <= 4'h0;
            bv_r <= 1'b0;
            br_r <= RESP_OKAY;
            rv_r <= 1'b0;
            rd_r <= 32'h0000_0000;
            rr_r <= RESP_OKAY;
            softRst_r <= 1'b0;
            swCount_r <= 32'h0000_0000;
        end else begin
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            bv_r <= bv_nxt;
            br_r <= br_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            rr_r <= rr_nxt;
            softRst_r <= softRst_nxt;
            swCount_r <= swCount_nxt;
        end
    end

    // Checks.
    sequence s_request;
        seeded_r && sw_r == SW_IDLE && selS != active_r && !softRst_r;
    endsequence
    chk_busy_on_request: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_request |=> busy_r && sw_r == SW_WAIT)
        else $error("Busy not raised on select change.");
    chk_stall_on_loss: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sw_r == SW_WAIT && (lostA || lostB) && !softRst_r |=> sw_r == SW_STALL
        && $stable(active_r))
        else $error("Switch not stalled on input loss.");
    chk_stall_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sw_r == SW_STALL && (lostA || lostB) && !softRst_r |=> sw_r == SW_STALL)
        else $error("Stall left while an input is lost.");
    chk_active_only_switch: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(seeded_r) && $changed(active_r) && !$past(softRst_r) |-> $past(sw_r) == SW_WAIT
        && $fell(busy_r))
        else $error("Active input changed outside a switchover.");
    chk_switch_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sw_r == SW_WAIT && !lostA && !lostB && running && !softRst_r
        |=> !busy_r && active_r == $past(req_r))
        else $error("Switch did not complete.");
    chk_outen_needs_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        outputDivEn |-> lockDetect)
        else $error("Output dividers enabled without lock.");
    chk_seed_from_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !seeded_r && pwr_r == ST_SCAN && !softRst_r |=> active_r == $past(selS))
        else $error("Active input not taken from select at reset.");
    chk_scan_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pwr_r == ST_SCAN |-> $past(pwr_r) == ST_REGUL)
        else $error("Strap scan out of order.");
    chk_cal_after_ref: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pwr_r == ST_WAITREF && !refLost && !softRst_r |=> pwr_r == ST_CAL ##1 calStart)
        else $error("Calibration not started.");
endmodule
`default_nettype wire

// ===== hdl/rsc_pkg.sv
/*
 * Package for the reference switch and power-on control block.
 * Holds register offsets, reset values, field positions and timing counts.
 * Assumes a 50 MHz system clock.
 */
package rsc_pkg;

    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned SYNC_STAGES = 2;

    // Register byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_STRAP = 8'h08;
    localparam logic [7:0] ADDR_SWCOUNT = 8'h0C;

    // Control register fields.
    localparam int CTRL_SOFT_RST_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status register fields.
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam int ST_OUTEN_BIT = 3;
    localparam int ST_STALL_BIT = 4;
    localparam int ST_LOSTA_BIT = 5;
    localparam int ST_LOSTB_BIT = 6;
    localparam int ST_LOSTM_BIT = 7;
    localparam int ST_STATE_LSB = 8;

    // Strap register fields.
    localparam int STRAP_MODE_BIT = 0;
    localparam int STRAP_MON_LSB = 4;

    // Strap widths and monitor configuration count.
    localparam int MON_STRAP_W = 3;
    localparam int MON_FREQ_COUNT = 5;

    // Loss detection: an input is lost below about 125 kHz, after no edge for four 1 MHz periods.
    localparam int unsigned LOST_FREQ_HZ = 1000000;
    localparam int unsigned LOST_WINDOW_CYC = CLK_HZ / LOST_FREQ_HZ;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_POR,
        ST_SUPPLY,
        ST_REGUL,
        ST_SCAN,
        ST_RXCFG,
        ST_WAITREF,
        ST_CAL,
        ST_WAITLOCK,
        ST_RUN
    } rsc_pwr_t;

    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT,
        SW_STALL
    } rsc_sw_t;

    function automatic logic [31:0] rsc_sel_bit(input logic v, input int pos);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pos] = v;
        return w;
    endfunction

endpackage

// ===== hdl/rsc_loss_det.sv
/*
 * Loss-of-clock detector for one input clock sampled on sys_clk.
 * Assumes the clock input is already synchronised to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_loss_det
    import rsc_pkg::*;
#(
    parameter int unsigned WINDOW = LOST_WINDOW_CYC * 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clkSync,
    output logic lost
);
    initial begin
        if (WINDOW < 2 || WINDOW > 65536) $error("rsc_loss_det: window out of range");
    end

    logic prev_r, prev_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic lost_r, lost_nxt;

    // A window without any edge of the input means the input is lost.
    always_comb begin
        prev_nxt = clkSync;
        cnt_nxt = cnt_r;
        lost_nxt = lost_r;
        if (clkSync != prev_r) begin
            cnt_nxt = 16'h0000;
            lost_nxt = 1'b0;
        end else if (cnt_r >= 16'(WINDOW - 1)) begin
            lost_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            cnt_r <= 16'h0000;
            lost_r <= 1'b1;
        end else begin
            prev_r <= prev_nxt;
            cnt_r <= cnt_nxt;
            lost_r <= lost_nxt;
        end
    end

    assign lost = lost_r;

    chk_lost_after_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cnt_r == 16'(WINDOW - 1)) && (clkSync == prev_r) |=> lost_r)
        else $error("Lost flag not raised after quiet window.");
endmodule
`default_nettype wire

// ===== verif/rsc_board_model.sv
/*
 * Model of the board around the control block: supply, regulator,
 * calibration, PLL lock and the three slow clocks.
 * Assumes the bench gates each clock with a run level.
 */
`timescale 1ns/1ps
`default_nettype none
module rsc_board_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic runA,
    input wire logic runB,
    input wire logic runM,
    input wire logic regulatorEn,
    input wire logic calStart,
    input wire logic pllRefSel,
    output logic supplyOk,
    output logic regulatorOk,
    output logic calDone,
    output logic pllLocked,
    output logic clockInputA,
    output logic clockInputB,
    output logic monitorClockIn
);
    logic [3:0] divA_r, divB_r, divM_r, regDly_r, calDly_r;
    logic refRun;
    assign refRun = pllRefSel ? runB : runA;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {divA_r, divB_r, divM_r, regDly_r, calDly_r} <= '0;
            {clockInputA, clockInputB, monitorClockIn} <= 3'h0;
            {supplyOk, regulatorOk, calDone, pllLocked} <= 4'h0;
        end else begin
            divA_r <= runA ? ((divA_r == 4'h9) ? 4'h0 : divA_r + 4'h1) : divA_r;
            divB_r <= runB ? ((divB_r == 4'h8) ? 4'h0 : divB_r + 4'h1) : divB_r;
            divM_r <= runM ? ((divM_r == 4'h7) ? 4'h0 : divM_r + 4'h1) : divM_r;
            clockInputA <= clockInputA ^ (runA && divA_r == 4'h9);
            clockInputB <= clockInputB ^ (runB && divB_r == 4'h8);
            monitorClockIn <= monitorClockIn ^ (runM && divM_r == 4'h7);
            supplyOk <= 1'b1;
            if (regulatorEn && regDly_r != 4'hF) begin
                regDly_r <= regDly_r + 4'h1;
            end
            regulatorOk <= regDly_r >= 4'h3;
            if ((calStart || calDly_r != 4'h0) && calDly_r != 4'hF) begin
                calDly_r <= calDly_r + 4'h1;
            end
            calDone <= calDly_r >= 4'h4;
            pllLocked <= (calDly_r >= 4'h8) && refRun;
        end
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
/*
 * Self-checking bench for the reference switch and power-on control.
 * Assumes the board model supplies clocks, supply, calibration and lock.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rsc_pkg::*;
    logic sys_clk, rst_n, inputModeStrap, sourceSelect, runA, runB, runM;
    logic [MON_STRAP_W-1:0] monitorClockStrap;
    logic supplyOk, regulatorOk, calDone, pllLocked, clockInputA, clockInputB, monitorClockIn;
    logic regulatorEn, rxDiffMode, monDiffMode, pllRefSel, refOutEn, calStart, lockDetect;
    logic outputDivEn, activeInputFlag, switchoverBusy;
    logic [2:0] monFreqSel;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rng, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int failures, testsRun, cycles;

    rsc_ctrl dut (.sys_clk, .rst_n, .supplyOk, .regulatorOk, .inputModeStrap, .monitorClockStrap,
        .clockInputA, .clockInputB, .monitorClockIn, .sourceSelect, .calDone, .pllLocked,
        .regulatorEn, .rxDiffMode, .monDiffMode, .monFreqSel, .pllRefSel, .refOutEn, .calStart,
        .lockDetect, .outputDivEn, .activeInputFlag, .switchoverBusy, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rsc_board_model board (.sys_clk, .rst_n, .runA, .runB, .runM, .regulatorEn, .calStart,
        .pllRefSel, .supplyOk, .regulatorOk, .calDone, .pllLocked, .clockInputA, .clockInputB,
        .monitorClockIn);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [3:0] monExp(input logic [2:0] s);
        return (s >= 3'h5) ? {1'b1, s - 3'h5} : {1'b0, s};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic waitLvl(input logic busySig, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((busySig ? switchoverBusy : lockDetect) !== v && n < lim);
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awDone, wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(negedge sys_clk);
            awDone = awDone | s_axi_awready;
            wDone = wDone | s_axi_wready;
            @(posedge sys_clk);
            if (awDone) s_axi_awvalid <= 1'b0;
            if (wDone) s_axi_wvalid <= 1'b0;
        end
        do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic bringUp(input logic mode, input logic [2:0] mon, input logic sel);
        int tries;
        tries = 0;
        do begin
            @(posedge sys_clk);
            rst_n <= 1'b0;
            inputModeStrap <= mode;
            monitorClockStrap <= mon;
            sourceSelect <= sel;
            repeat (3) @(posedge sys_clk);
            rst_n <= 1'b1;
            waitLvl(1'b0, 1'b1, 2000);
            tries++;
        end while (lockDetect !== 1'b1 && tries < 3);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        {rst_n, inputModeStrap, sourceSelect, monitorClockStrap} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {runA, runB, runM} = 3'h7;
        rng = 32'h0000_0024;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            bringUp(rng[0], 3'(i), rng[1]);
            check("lock", 32'(lockDetect), 32'h1);
            check("divider enable", 32'(outputDivEn), 32'h1);
            check("input mode", 32'(rxDiffMode), 32'(rng[0]));
            check("monitor cfg", 32'({monDiffMode, monFreqSel}), 32'(monExp(3'(i))));
            check("active after reset", 32'(activeInputFlag), 32'(rng[1]));
            check("pll reference", 32'(pllRefSel), 32'(rng[1]));
            axiRead(ADDR_STRAP, rd, resp);
            check("strap reg", rd & 32'h0000_0071, {25'h0, 3'(i), 3'h0, rng[0]});
            $display("Test strap %0d done", i);
        end
        bringUp(1'b0, 3'h0, 1'b0);
        @(posedge sys_clk);
        runM <= 1'b0;
        repeat (300) @(negedge sys_clk);
        check("no auto switch", 32'({activeInputFlag, switchoverBusy}), 32'h0);
        axiRead(ADDR_STATUS, rd, resp);
        check("monitor lost", rd & 32'h0000_0080, 32'h0000_0080);
        @(posedge sys_clk);
        runM <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            sourceSelect <= ~sourceSelect;
            waitLvl(1'b1, 1'b1, 10);
            check("busy raised", 32'(switchoverBusy), 32'h1);
            check("active before switch", 32'(activeInputFlag), 32'(k[0]));
            waitLvl(1'b1, 1'b0, 50);
            check("switched", 32'(activeInputFlag), 32'(!k[0]));
        end
        $display("Test switch done");
        @(posedge sys_clk);
        runB <= 1'b0;
        repeat (300) @(posedge sys_clk);
        sourceSelect <= 1'b1;
        repeat (100) @(negedge sys_clk);
        check("stall busy", 32'(switchoverBusy), 32'h1);
        check("stall keeps a", 32'(activeInputFlag), 32'h0);
        @(posedge sys_clk);
        runB <= 1'b1;
        waitLvl(1'b1, 1'b0, 600);
        check("resumed to b", 32'(activeInputFlag), 32'h1);
        axiRead(ADDR_STATUS, rd, resp);
        check("status", rd & 32'h0000_000F, 32'h0000_000D);
        axiRead(ADDR_SWCOUNT, rd, resp);
        check("switch count", rd, 32'h0000_0003);
        $display("Test stall done");
        @(posedge sys_clk);
        runA <= 1'b0;
        repeat (300) @(posedge sys_clk);
        sourceSelect <= 1'b0;
        waitLvl(1'b1, 1'b1, 10);
        check("stall on a lost", 32'(switchoverBusy), 32'h1);
        axiRead(ADDR_STATUS, rd, resp);
        check("stall status", rd & 32'h0000_0013, 32'h0000_0013);
        @(posedge sys_clk);
        runB <= 1'b0;
        waitLvl(1'b0, 1'b0, 10);
        check("active lost drops lock", 32'(lockDetect), 32'h0);
        @(posedge sys_clk);
        runB <= 1'b1;
        bringUp(1'b1, 3'h5, 1'b1);
        check("reset cancels", 32'({activeInputFlag, switchoverBusy}), 32'h2);
        @(posedge sys_clk);
        runA <= 1'b1;
        axiRead(8'h10, rd, resp);
        check("unmapped read", {rd[29:0], resp}, {30'h0, RESP_SLVERR});
        axiWrite(8'h10, 32'h0000_0001, resp);
        check("unmapped write", 32'(resp), 32'(RESP_SLVERR));
        axiWrite(ADDR_CTRL, 32'h0000_0000, resp);
        check("ctrl write", 32'(resp), 32'(RESP_OKAY));
        axiWrite(ADDR_CTRL, 32'h0000_0001, resp);
        waitLvl(1'b0, 1'b0, 10);
        check("soft reset drops lock", 32'(lockDetect), 32'h0);
        waitLvl(1'b0, 1'b1, 2000);
        check("relock after soft reset", 32'(lockDetect), 32'h1);
        check("active after soft reset", 32'(activeInputFlag), 32'h1);
        $display("Test bus done");
        stop_test();
    end
endmodule
`default_nettype wire
